//--- design/swp_pkg.sv
// types shared by the sector write protection block
// assumes nothing beyond a SystemVerilog compiler
package swp_pkg;

  // sequencer states, gray along idle -> preprogram -> verify -> erase
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PREPROG = 3'h1,
    ST_VERIFY = 3'h3,
    ST_ERASE = 3'h2,
    ST_NVPROG = 3'h6,
    ST_CFGPROG = 3'h7,
    ST_PWDPROG = 3'h5,
    ST_UNLOCK = 3'h4
  } swp_state_t;

  // command opcodes in the low nibble of the command register
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_NV_PROG = 4'h1,
    OP_NV_ERASE = 4'h2,
    OP_VOL_SET = 4'h3,
    OP_VOL_CLR = 4'h4,
    OP_FREEZE = 4'h5,
    OP_UNLOCK = 4'h6,
    OP_CFG_PROG = 4'h7,
    OP_PWD_PROG = 4'h8,
    OP_ARR_PROG = 4'h9,
    OP_ARR_ERASE = 4'ha,
    OP_CLR_STATUS = 4'hb,
    OP_OVL_ENTER = 4'hc,
    OP_OVL_EXIT = 4'hd
  } swp_op_t;

endpackage

//--- design/swp_regs.svh
// register offsets, field positions, reset values and timing figures of the sector write protection block
// assumes a 32-bit register port with byte addresses of 8 bits
`ifndef SWP_REGS_SVH
`define SWP_REGS_SVH

// register byte offsets
`define SWP_CMD_OFS 8'h00
`define SWP_STATUS_OFS 8'h04
`define SWP_CONFIG_OFS 8'h08
`define SWP_LOCKSTAT_OFS 8'h0c
`define SWP_KEY0_OFS 8'h10
`define SWP_KEY1_OFS 8'h14
`define SWP_KEY2_OFS 8'h18
`define SWP_KEY3_OFS 8'h1c

// command word fields
`define SWP_CMD_OP_LSB 0
`define SWP_CMD_SEC_LSB 8
`define SWP_CMD_DATA_LSB 16

// protection_config_word fields
`define SWP_CFG_TRAP 13
`define SWP_CFG_HYBRID 11
`define SWP_CFG_ECC 9
`define SWP_CFG_RDPWD 5
`define SWP_CFG_PWDLOCK 2
`define SWP_CFG_PERSLOCK 1
`define SWP_CFG_RESET 16'hfeff
`define SWP_CFG_OTP_MASK 16'h2a26
`define SWP_PWD_RESET 16'hffff

// status_word bits
`define SWP_SR_READY 7
`define SWP_SR_ERASE_FAIL 5
`define SWP_SR_PROG_FAIL 4
`define SWP_SR_LOCK_FAIL 1

// timing figures
`define SWP_CLK_NS 10
`define SWP_T_PSWD_US 100
`define SWP_T_PROG_NS 1000
`define SWP_T_ERASE_NS 5000

`endif

//--- design/swp_sector_lock.sv
// one sector's nonvolatile and volatile lock bits and its write permit
// assumes strobes from the sequencer are one cycle long and already qualified
module swp_sector_lock (
  input wire logic core_clk, // system clock
  input wire logic rst, // hardware reset, sync, high
  input wire logic power_on, // power-on reset, sync, high
  input wire logic nv_prog, // program this sector's nonvolatile lock to 0
  input wire logic nv_preprog, // group preprogram to 0
  input wire logic nv_erase, // group erase to 1
  input wire logic vol_set, // volatile lock to 0
  input wire logic vol_clr, // volatile lock to 1
  output logic nonvolatile_sector_lock_ff, // 0 means protected
  output logic volatile_sector_lock_ff, // 0 means protected
  output logic permit_ff // sector may be written
);

  // nonvolatile bit survives hardware reset; of the two resets only power-on restores the erased state
  always_ff @(posedge core_clk) begin
    if (power_on) begin
      nonvolatile_sector_lock_ff <= 1'b1;
    end else if (nv_erase) begin
      nonvolatile_sector_lock_ff <= 1'b1;
    end else if (nv_prog || nv_preprog) begin
      nonvolatile_sector_lock_ff <= 1'b0;
    end
  end

  // volatile bit forgets everything at either reset
  always_ff @(posedge core_clk) begin
    if (rst || power_on) begin
      volatile_sector_lock_ff <= 1'b1;
    end else if (vol_set) begin
      volatile_sector_lock_ff <= 1'b0;
    end else if (vol_clr) begin
      volatile_sector_lock_ff <= 1'b1;
    end
  end

  // permit lags the lock bits by one cycle; the sequencer checks the bits directly
  always_ff @(posedge core_clk) begin
    if (rst || power_on) begin
      permit_ff <= 1'b1;
    end else begin
      permit_ff <= nonvolatile_sector_lock_ff & volatile_sector_lock_ff;
    end
  end

endmodule

//--- design/swp_sector_write_protect.sv
// sector write protection: lock bits, lock freeze, configuration word, password unlock
// assumes a single-cycle register port master and a flash datapath that obeys the go pulses
//
// Local design decisions: the register addresses and the strobed register port.
`include "swp_regs.svh"

module swp_sector_write_protect #(
  parameter int NSECT = 256, // number of sectors
  parameter int SECT_W = $clog2(NSECT), // sector index width, at most 8
  parameter int PROG_CYCLES = (`SWP_T_PROG_NS + `SWP_CLK_NS - 1) / `SWP_CLK_NS, // lock word program
  parameter int ERASE_CYCLES = (`SWP_T_ERASE_NS + `SWP_CLK_NS - 1) / `SWP_CLK_NS, // lock group erase
  parameter int PSWD_CYCLES = (`SWP_T_PSWD_US * 1000 + `SWP_CLK_NS - 1) / `SWP_CLK_NS // unlock spacing
) (
  input wire logic core_clk, // system clock, 100 MHz
  input wire logic rst, // hardware reset, sync, high
  input wire logic power_on, // power-on reset, sync, high
  input wire logic [7:0] bus_addr, // register byte address
  input wire logic [31:0] bus_wdata, // register write data
  input wire logic bus_wr, // write strobe
  input wire logic bus_rd, // read strobe
  output logic [31:0] bus_rdata_ff, // read data, cycle after strobe
  output logic device_ready_ff, // sequencer idle
  output logic array_prog_go_ff, // permitted array program pulse
  output logic array_erase_go_ff, // permitted array erase pulse
  output logic [SECT_W-1:0] array_sector_ff, // sector of the go pulse
  output logic [NSECT-1:0] sector_permit_ff, // per-sector write permit
  output logic lock_freeze_ff, // 1 lets nonvolatile locks change
  output logic trap_single_bit_ff, // trap also catches single errors
  output logic hybrid_burst_ff, // hybrid burst selected
  output logic ecc_onoff_en_ff, // ecc on-off control enabled
  output logic dual_error_detect_ff, // dual error detect enabled
  output logic read_password_mode_ff, // read-password mode enabled
  output logic password_mgmt_ff // password management selected
);
  import swp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  swp_state_t state_ff;
  logic [23:0] cnt_ff;
  logic [SECT_W-1:0] sec_ff;
  logic [1:0] widx_ff;
  logic [15:0] data_ff;
  logic [15:0] protection_config_word_ff;
  logic [15:0] pwd_ff [4];
  logic [15:0] ukey_ff [4];
  logic sr_prog_fail_ff;
  logic sr_erase_fail_ff;
  logic sr_lock_fail_ff;
  logic ovl_on_ff;
  logic [SECT_W-1:0] ovl_sec_ff;
  logic [NSECT-1:0] nv_vec;
  logic [NSECT-1:0] vol_vec;

  // command decode; every command is ignored while the sequencer is busy, key register writes are not
  logic cmd_go;
  swp_op_t op;
  logic [SECT_W-1:0] cmd_sec;
  logic [15:0] cmd_data;
  logic idle;
  logic done;
  logic pwd_mode;
  logic key_match;
  logic cmd_permit;
  assign idle = (state_ff == ST_IDLE);
  assign cmd_go = bus_wr && (bus_addr == `SWP_CMD_OFS) && idle;
  assign op = swp_op_t'(bus_wdata[`SWP_CMD_OP_LSB +: 4]);
  assign cmd_sec = bus_wdata[`SWP_CMD_SEC_LSB +: SECT_W];
  assign cmd_data = bus_wdata[`SWP_CMD_DATA_LSB +: 16];
  assign done = !idle && (cnt_ff == 24'h000000);
  assign pwd_mode = (protection_config_word_ff[`SWP_CFG_PWDLOCK:`SWP_CFG_PERSLOCK] == 2'b01);
  assign key_match = ({pwd_ff[0], pwd_ff[1], pwd_ff[2], pwd_ff[3]} ==
                      {ukey_ff[0], ukey_ff[1], ukey_ff[2], ukey_ff[3]});
  assign cmd_permit = nv_vec[cmd_sec] & vol_vec[cmd_sec];

  // refusals and late failures
  logic nv_refuse;
  logic cfg_refuse;
  logic pwd_refuse;
  logic arr_refuse;
  logic verify_bad;
  logic unlock_bad;
  assign nv_refuse = cmd_go && ((op == OP_NV_PROG) || (op == OP_NV_ERASE)) && !lock_freeze_ff;
  assign cfg_refuse = cmd_go && (op == OP_CFG_PROG) &&
    ((protection_config_word_ff[`SWP_CFG_PWDLOCK:`SWP_CFG_PERSLOCK] != 2'b11) ||
     (cmd_data[`SWP_CFG_PWDLOCK:`SWP_CFG_PERSLOCK] == 2'b00));
  assign pwd_refuse = cmd_go && (op == OP_PWD_PROG) && !protection_config_word_ff[`SWP_CFG_PWDLOCK];
  assign arr_refuse = cmd_go && ((op == OP_ARR_PROG) || (op == OP_ARR_ERASE)) && !cmd_permit;
  assign verify_bad = (state_ff == ST_VERIFY) && (|nv_vec);
  assign unlock_bad = (state_ff == ST_UNLOCK) && done && !(pwd_mode && key_match);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer; lock program, preprogram, verify, erase, config and password program, unlock
  always_ff @(posedge core_clk) begin
    if (rst || power_on) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 24'h000000;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (cmd_go && lock_freeze_ff && (op == OP_NV_PROG)) begin
            state_ff <= ST_NVPROG;
            cnt_ff <= 24'(PROG_CYCLES - 1);
          end else if (cmd_go && lock_freeze_ff && (op == OP_NV_ERASE)) begin
            state_ff <= ST_PREPROG;
            cnt_ff <= 24'(PROG_CYCLES - 1);
          end else if (cmd_go && (op == OP_CFG_PROG) && !cfg_refuse) begin
            state_ff <= ST_CFGPROG;
            cnt_ff <= 24'(PROG_CYCLES - 1);
          end else if (cmd_go && (op == OP_PWD_PROG) && !pwd_refuse) begin
            state_ff <= ST_PWDPROG;
            cnt_ff <= 24'(PROG_CYCLES - 1);
          end else if (cmd_go && (op == OP_UNLOCK)) begin
            state_ff <= ST_UNLOCK;
            cnt_ff <= 24'(PSWD_CYCLES - 1);
          end
        end
        ST_PREPROG: begin
          if (done) begin
            state_ff <= ST_VERIFY;
          end else begin
            cnt_ff <= cnt_ff - 24'h000001;
          end
        end
        ST_VERIFY: begin
          if (verify_bad) begin
            state_ff <= ST_IDLE;
          end else begin
            state_ff <= ST_ERASE;
            cnt_ff <= 24'(ERASE_CYCLES - 1);
          end
        end
        default: begin
          if (done) begin
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 24'h000001;
          end
        end
      endcase
    end
  end

  // operands captured with the command
  always_ff @(posedge core_clk) begin
    if (rst || power_on) begin
      sec_ff <= '0;
      widx_ff <= 2'h0;
      data_ff <= 16'hffff;
    end else if (cmd_go) begin
      sec_ff <= cmd_sec;
      widx_ff <= cmd_sec[1:0];
      data_ff <= cmd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-sector lock cells
  logic nv_prog_now;
  logic nv_preprog_now;
  logic nv_erase_now;
  assign nv_prog_now = (state_ff == ST_NVPROG) && done;
  assign nv_preprog_now = (state_ff == ST_PREPROG) && done;
  assign nv_erase_now = (state_ff == ST_ERASE) && done;

  for (genvar i = 0; i < NSECT; i++) begin : g_sect
    swp_sector_lock u_lock (
      .core_clk(core_clk),
      .rst(rst),
      .power_on(power_on),
      .nv_prog(nv_prog_now && (sec_ff == SECT_W'(i))),
      .nv_preprog(nv_preprog_now),
      .nv_erase(nv_erase_now),
      .vol_set(cmd_go && (op == OP_VOL_SET) && (cmd_sec == SECT_W'(i))),
      .vol_clr(cmd_go && (op == OP_VOL_CLR) && (cmd_sec == SECT_W'(i))),
      .nonvolatile_sector_lock_ff(nv_vec[i]),
      .volatile_sector_lock_ff(vol_vec[i]),
      .permit_ff(sector_permit_ff[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-time-programmable config word; bits only move from 1 to 0, reserved bits never
  always_ff @(posedge core_clk) begin
    if (power_on) begin
      protection_config_word_ff <= `SWP_CFG_RESET;
    end else if ((state_ff == ST_CFGPROG) && done) begin
      protection_config_word_ff <= protection_config_word_ff & (data_ff | ~`SWP_CFG_OTP_MASK);
    end
  end

  // hidden password, program only writes zeros; unlock key words take any order
  always_ff @(posedge core_clk) begin
    if (power_on) begin
      pwd_ff <= '{default: `SWP_PWD_RESET};
    end else if ((state_ff == ST_PWDPROG) && done) begin
      pwd_ff[widx_ff] <= pwd_ff[widx_ff] & data_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || power_on) begin
      ukey_ff <= '{default: 16'h0000};
    end else if (bus_wr && (bus_addr == `SWP_KEY0_OFS)) begin
      ukey_ff[0] <= bus_wdata[15:0];
    end else if (bus_wr && (bus_addr == `SWP_KEY1_OFS)) begin
      ukey_ff[1] <= bus_wdata[15:0];
    end else if (bus_wr && (bus_addr == `SWP_KEY2_OFS)) begin
      ukey_ff[2] <= bus_wdata[15:0];
    end else if (bus_wr && (bus_addr == `SWP_KEY3_OFS)) begin
      ukey_ff[3] <= bus_wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock freeze; the reset value follows the management mode chosen in the config word
  always_ff @(posedge core_clk) begin
    if (power_on) begin
      lock_freeze_ff <= 1'b1;
    end else if (rst) begin
      lock_freeze_ff <= !pwd_mode;
    end else if (cmd_go && (op == OP_FREEZE)) begin
      lock_freeze_ff <= 1'b0;
    end else if ((state_ff == ST_UNLOCK) && done && pwd_mode && key_match) begin
      lock_freeze_ff <= 1'b1;
    end
  end

  // sticky failure flags, cleared by command; a set in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (rst || power_on) begin
      sr_prog_fail_ff <= 1'b0;
      sr_erase_fail_ff <= 1'b0;
      sr_lock_fail_ff <= 1'b0;
    end else begin
      sr_prog_fail_ff <= (sr_prog_fail_ff && !(cmd_go && (op == OP_CLR_STATUS))) ||
        (nv_refuse && (op == OP_NV_PROG)) || cfg_refuse || pwd_refuse || unlock_bad ||
        (arr_refuse && (op == OP_ARR_PROG));
      sr_erase_fail_ff <= (sr_erase_fail_ff && !(cmd_go && (op == OP_CLR_STATUS))) ||
        (nv_refuse && (op == OP_NV_ERASE)) || verify_bad || (arr_refuse && (op == OP_ARR_ERASE));
      sr_lock_fail_ff <= (sr_lock_fail_ff && !(cmd_go && (op == OP_CLR_STATUS))) ||
        nv_refuse || cfg_refuse || pwd_refuse || unlock_bad || arr_refuse;
    end
  end

  // lock status overlay and the sector it addresses
  always_ff @(posedge core_clk) begin
    if (rst || power_on) begin
      ovl_on_ff <= 1'b0;
      ovl_sec_ff <= '0;
    end else if (cmd_go && (op == OP_OVL_ENTER)) begin
      ovl_on_ff <= 1'b1;
      ovl_sec_ff <= cmd_sec;
    end else if (cmd_go && (op == OP_OVL_EXIT)) begin
      ovl_on_ff <= 1'b0;
    end
  end

  // array go pulses only for sectors whose both lock bits are 1
  always_ff @(posedge core_clk) begin
    if (rst || power_on) begin
      array_prog_go_ff <= 1'b0;
      array_erase_go_ff <= 1'b0;
      array_sector_ff <= '0;
    end else begin
      array_prog_go_ff <= cmd_go && (op == OP_ARR_PROG) && cmd_permit;
      array_erase_go_ff <= cmd_go && (op == OP_ARR_ERASE) && cmd_permit;
      if (cmd_go) begin
        array_sector_ff <= cmd_sec;
      end
    end
  end

  // decoded config options for the burst, ecc and password logic, and the ready flag
  always_ff @(posedge core_clk) begin
    if (rst || power_on) begin
      trap_single_bit_ff <= 1'b0;
      hybrid_burst_ff <= 1'b0;
      ecc_onoff_en_ff <= 1'b1;
      dual_error_detect_ff <= 1'b0;
      read_password_mode_ff <= 1'b0;
      password_mgmt_ff <= 1'b0;
      device_ready_ff <= 1'b1;
    end else begin
      trap_single_bit_ff <= !protection_config_word_ff[`SWP_CFG_TRAP];
      hybrid_burst_ff <= !protection_config_word_ff[`SWP_CFG_HYBRID];
      ecc_onoff_en_ff <= protection_config_word_ff[`SWP_CFG_ECC];
      dual_error_detect_ff <= !protection_config_word_ff[`SWP_CFG_ECC];
      read_password_mode_ff <= !protection_config_word_ff[`SWP_CFG_RDPWD];
      password_mgmt_ff <= pwd_mode;
      device_ready_ff <= idle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read; data only in the cycle after the strobe, unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (rst || power_on || !bus_rd) begin
      bus_rdata_ff <= 32'h00000000;
    end else if (bus_addr == `SWP_STATUS_OFS) begin
      bus_rdata_ff <= 32'h00000000;
      bus_rdata_ff[`SWP_SR_READY] <= idle;
      bus_rdata_ff[`SWP_SR_ERASE_FAIL] <= sr_erase_fail_ff;
      bus_rdata_ff[`SWP_SR_PROG_FAIL] <= sr_prog_fail_ff;
      bus_rdata_ff[`SWP_SR_LOCK_FAIL] <= sr_lock_fail_ff;
    end else if (bus_addr == `SWP_CONFIG_OFS) begin
      bus_rdata_ff <= {16'h0000, protection_config_word_ff};
    end else if ((bus_addr == `SWP_LOCKSTAT_OFS) && ovl_on_ff) begin
      bus_rdata_ff <= {28'h0000000, ovl_on_ff, lock_freeze_ff, vol_vec[ovl_sec_ff], nv_vec[ovl_sec_ff]};
    end else begin
      bus_rdata_ff <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || power_on);

  sequence s_erase_cmd;
    cmd_go && (op == OP_NV_ERASE) && lock_freeze_ff;
  endsequence
  sequence s_preprog_run;
    (state_ff == ST_PREPROG) && (nv_vec == $past(nv_vec));
  endsequence
  sequence s_unlock_good;
    (state_ff == ST_UNLOCK) && done && pwd_mode && key_match;
  endsequence

  property p_freeze_abort;
    cmd_go && (op == OP_NV_PROG) && !lock_freeze_ff |=> idle && sr_prog_fail_ff && sr_lock_fail_ff;
  endproperty
  a_freeze_abort: assert property (p_freeze_abort) else $error("lock program ran with freeze low");

  property p_permit;
    cmd_go && (op == OP_ARR_PROG) && !(nv_vec[cmd_sec] && vol_vec[cmd_sec])
      |=> !array_prog_go_ff && sr_lock_fail_ff;
  endproperty
  a_permit: assert property (p_permit) else $error("protected sector got a program go");

  property p_cfg_both;
    cmd_go && (op == OP_CFG_PROG) && (cmd_data[2:1] == 2'b00)
      |=> sr_prog_fail_ff && sr_lock_fail_ff && $stable(protection_config_word_ff);
  endproperty
  a_cfg_both: assert property (p_cfg_both) else $error("both mode lock bits accepted");

  property p_cfg_frozen;
    cmd_go && (op == OP_CFG_PROG) && (protection_config_word_ff[2:1] != 2'b11) |-> ##1 idle [*2];
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("frozen config word accepted a program");

  property p_vol_reset;
    $past(rst) |-> (&vol_vec);
  endproperty
  a_vol_reset: assert property (p_vol_reset) else $error("volatile lock survived reset");

  property p_freeze_reset;
    $past(rst) && !$past(power_on) |-> (lock_freeze_ff == !pwd_mode);
  endproperty
  a_freeze_reset: assert property (p_freeze_reset) else $error("lock freeze wrong after reset");

  property p_no_reset_set;
    !pwd_mode && !lock_freeze_ff |=> !lock_freeze_ff;
  endproperty
  a_no_reset_set: assert property (p_no_reset_set) else $error("persistent freeze rose without reset");

  property p_freeze_cmd;
    cmd_go && (op == OP_FREEZE) |=> !lock_freeze_ff;
  endproperty
  a_freeze_cmd: assert property (p_freeze_cmd) else $error("freeze command did not clear");

  property p_unlock;
    s_unlock_good |=> lock_freeze_ff && $stable(sr_lock_fail_ff);
  endproperty
  a_unlock: assert property (p_unlock) else $error("good unlock did not set freeze");

  property p_erase_start;
    s_erase_cmd |=> s_preprog_run;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("group erase skipped preprogram");

  property p_erase_end;
    (state_ff == ST_ERASE) && done |=> (&nv_vec) && idle;
  endproperty
  a_erase_end: assert property (p_erase_end) else $error("group erase left a lock programmed");

  property p_status_busy;
    bus_rd && (bus_addr == `SWP_STATUS_OFS) && !idle |=> !bus_rdata_ff[`SWP_SR_READY];
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("status showed ready while busy");

  property p_vol_set;
    cmd_go && (op == OP_VOL_SET) |=> !vol_vec[$past(cmd_sec)];
  endproperty
  a_vol_set: assert property (p_vol_set) else $error("volatile set did not protect");

  property p_ecc_excl;
    ecc_onoff_en_ff != dual_error_detect_ff;
  endproperty
  a_ecc_excl: assert property (p_ecc_excl) else $error("ecc control and dual detect agree");

endmodule

//--- verif/swp_host.sv
// host controller model driving the block's register port
// assumes one clock; read data stands one cycle after the strobe
module swp_host (
  input wire logic core_clk, // system clock
  input wire logic [31:0] bus_rdata_ff, // read data
  output logic [7:0] bus_addr, // byte address
  output logic [31:0] bus_wdata, // write data
  output logic bus_wr, // write strobe
  output logic bus_rd // read strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_addr = 8'h0;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // released lines show the inverse, so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~v;
  endtask
  // data taken in its only valid cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    #1;
    v = bus_rdata_ff;
  endtask
endmodule

//--- verif/tb.sv
// bench for sector write protection: lock-bit model against the design
// assumes short sequencer counts and a fresh persistent-mode part
`include "swp_regs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("wrong value %0t %h", $time, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swp_pkg::*;
  logic core_clk, rst = 1, power_on = 1, bus_wr, bus_rd, rdy, pg, eg, frz_o;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata_ff, d;
  logic [1:0] asec;
  logic [3:0] permit;
  logic [5:0] cfg_o;
  logic [15:0] pw [4];
  int num_errors = 0, checks = 0, seed = 32'hacaa, cyc = 0, gos = 0, s, t, frz;
  int nv[4], vol[4];
  swp_sector_write_protect #(.NSECT(4), .PROG_CYCLES(3), .ERASE_CYCLES(4), .PSWD_CYCLES(5)) dut (
    .core_clk, .rst, .power_on, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_ff, .device_ready_ff(rdy),
    .array_prog_go_ff(pg), .array_erase_go_ff(eg), .array_sector_ff(asec), .sector_permit_ff(permit),
    .lock_freeze_ff(frz_o), .trap_single_bit_ff(cfg_o[5]), .hybrid_burst_ff(cfg_o[4]), .ecc_onoff_en_ff(cfg_o[3]),
    .dual_error_detect_ff(cfg_o[2]), .read_password_mode_ff(cfg_o[1]), .password_mgmt_ff(cfg_o[0]));
  swp_host h (.core_clk, .bus_rdata_ff, .bus_addr, .bus_wdata, .bus_wr, .bus_rd);
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // hang ceiling and go-pulse tally
  // counted on the falling edge, where the design's registers have settled
  always @(negedge core_clk) begin
    cyc++;
    gos += int'(pg | eg);
    if (cyc == 3000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // command, then bounded wait for idle plus one cycle for permit
  task automatic cmd(input logic [3:0] op, input int sc, input logic [15:0] dt = 16'hffff, input bit busy = 0);
    h.wr(`SWP_CMD_OFS, {dt, sc[7:0], 4'h0, op});
    if (busy) begin
      h.rd(`SWP_STATUS_OFS, d);
      `CHK(d[7], 1'b0)
    end
    repeat (2) @(posedge core_clk);
    #1;
    for (int i = 0; i < 60 && rdy !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK(rdy, 1'b1)
    @(posedge core_clk);
    #1;
  endtask
  task automatic perm();
    foreach (nv[i]) `CHK(permit[i], 1'(nv[i] & vol[i]))
    `CHK(frz_o, 1'(frz))
  endtask
  // status is sticky, so clear it after each look
  task automatic stat(input logic [7:0] e);
    h.rd(`SWP_STATUS_OFS, d);
    `CHK(d[7:0], e)
    cmd(OP_CLR_STATUS, 0);
  endtask
  initial begin
    foreach (nv[i]) begin
      nv[i] = 1;
      vol[i] = 1;
    end
    frz = 1;
    repeat (2) @(posedge core_clk);
    rst <= 0;
    power_on <= 0;
    repeat (2) @(posedge core_clk);
    #1;
    perm();
    h.rd(`SWP_CONFIG_OFS, d);
    `CHK(d[15:0], `SWP_CFG_RESET)
    s = {$random(seed)} % 4;
    t = s ^ 1;
    cmd(OP_VOL_SET, s);
    vol[s] = 0;
    perm();
    cmd(OP_ARR_PROG, s);
    stat(8'h92);
    cmd(OP_ARR_ERASE, t);
    `CHK(gos, 1)
    `CHK(asec, t[1:0])
    cmd(OP_ARR_PROG, t);
    `CHK(gos, 2)
    cmd(OP_VOL_CLR, s);
    vol[s] = 1;
    perm();
    cmd(OP_NV_PROG, t);
    nv[t] = 0;
    perm();
    cmd(OP_OVL_ENTER, t);
    h.rd(`SWP_LOCKSTAT_OFS, d);
    `CHK(d[3:0], 4'he)
    cmd(OP_OVL_EXIT, 0);
    cmd(OP_NV_ERASE, 0, 16'hffff, 1);
    nv[t] = 1;
    perm();
    cmd(OP_FREEZE, 0);
    frz = 0;
    perm();
    cmd(OP_NV_PROG, s);
    stat(8'h92);
    cmd(OP_NV_ERASE, 0);
    stat(8'ha2);
    cmd(OP_UNLOCK, 0);
    stat(8'h92);
    cmd(OP_VOL_SET, s);
    vol[s] = 0;
    perm();
    cmd(OP_CFG_PROG, 0, 16'hfff9);
    stat(8'h92);
    cmd(OP_CFG_PROG, 0, 16'hd5dd);
    h.rd(`SWP_CONFIG_OFS, d);
    `CHK(d[15:0], 16'hd4dd)
    `CHK(cfg_o, 6'b110110)
    cmd(OP_CFG_PROG, 0, 16'hfffb);
    stat(8'h92);
    rst <= 1;
    @(posedge core_clk);
    rst <= 0;
    vol[s] = 1;
    frz = 1;
    repeat (2) @(posedge core_clk);
    #1;
    perm();
    // second life: factory part taken to password management
    @(posedge core_clk);
    power_on <= 1;
    @(posedge core_clk);
    power_on <= 0;
    repeat (2) @(posedge core_clk);
    #1;
    foreach (pw[i]) begin
      pw[i] = 16'($random(seed));
      cmd(OP_PWD_PROG, i, pw[i]);
    end
    cmd(OP_CFG_PROG, 0, 16'hfffb);
    h.rd(`SWP_CONFIG_OFS, d);
    `CHK(d[15:0], 16'hfefb)
    `CHK(cfg_o[0], 1'b1)
    cmd(OP_PWD_PROG, 0, 16'h0000);
    stat(8'h92);
    rst <= 1;
    @(posedge core_clk);
    rst <= 0;
    frz = 0;
    repeat (2) @(posedge core_clk);
    #1;
    perm();
    cmd(OP_UNLOCK, 0);
    stat(8'h92);
    // key words go in backwards, each to its own register; the unlock compare matches by position
    for (int k = 3; k >= 0; k--) h.wr(8'(`SWP_KEY0_OFS + 4 * k), {16'h0000, pw[k]});
    cmd(OP_UNLOCK, 0);
    frz = 1;
    perm();
    cmd(OP_FREEZE, 0);
    frz = 0;
    perm();
    test_done();
  end
endmodule
